/* File: hdl/sk_socket_status.sv */
`timescale 1ns/1ps
// Operation
// - one read-only 8-bit status register per socket at base plus socket index times stride
// - released is 0x00; close and resolution expiry force it from anywhere, tcp retry expiry from tcp states only
// - open with TCP selected enters tcp initial, code 0x13
// - listen enters server waiting, code 0x14, awaiting a client request
// - server waiting goes request received on a client request, else timeout flag, released
// - connected is 0x17; send and receive commands accepted there
// - peer FIN gives half closed 0x1C; host tears down or closes
// - open with UDP selected enters datagram open, code 0x22
// - open with raw IP selected enters raw ip open, code 0x32
// - socket zero only: raw Ethernet open gives raw frame, 0x42
// - socket zero only: session open gives session setup, 0x5F
// - connect sends request, 0x15; reply connects, expiry releases
// - client request seen gives 0x16; reply sent connects, else releases
// - teardown shows 0x18, 0x1A, 0x1B; done or expiry releases
module sk_socket_status #(
    parameter int unsigned SOCK_IDX = 0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register access
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // host command and protocol select
    input wire sk_pkg::sk_cmd_s socket_command,
    input wire logic [3:0] socket_protocol_select,
    input wire logic timeout_flag_ack,
    // packet engine events and requests
    input wire sk_pkg::sk_evt_s pkt_evt,
    output logic send_syn,
    output logic send_synack,
    output logic send_fin,
    output logic send_req,
    output logic recv_req,
    // status
    output logic [7:0] state_code,
    output logic timeout_flag,
    output logic data_enable
);
    import sk_pkg::*;
    typedef enum logic [12:0] {
        ST_RELEASED = 13'h0001,
        ST_TCP_INITIAL = 13'h0002,
        ST_SERVER_WAITING = 13'h0004,
        ST_REQUEST_SENT = 13'h0008,
        ST_REQUEST_RECEIVED = 13'h0010,
        ST_CONNECTED = 13'h0020,
        ST_HALF_CLOSED = 13'h0040,
        ST_TEARDOWN_WAIT = 13'h0080,
        ST_TEARDOWN_BOTH = 13'h0100,
        ST_TEARDOWN_LINGER = 13'h0200,
        ST_DATAGRAM_OPEN = 13'h0400,
        ST_RAW_IP_OPEN = 13'h0800,
        ST_RAW_FRAME_OPEN = 13'h1000
    } sk_state_e;
    // session setup shares the raw frame slot would hide a code; own flag
    sk_state_e state;
    sk_state_e next_state;
    logic session;
    logic next_session;
    logic is_tcp;
    logic abort;
    logic expiry_hit;
    logic [15:0] my_addr;

    // status code for a state
    function automatic logic [7:0] code_of(sk_state_e s, logic ses);
        logic [7:0] c;
        c = CODE_RELEASED;
        unique case (s)
            ST_RELEASED: c = ses ? CODE_SESSION_SETUP : CODE_RELEASED;
            ST_TCP_INITIAL: c = CODE_TCP_INITIAL;
            ST_SERVER_WAITING: c = CODE_SERVER_WAITING;
            ST_REQUEST_SENT: c = CODE_REQUEST_SENT;
            ST_REQUEST_RECEIVED: c = CODE_REQUEST_RECEIVED;
            ST_CONNECTED: c = CODE_CONNECTED;
            ST_HALF_CLOSED: c = CODE_HALF_CLOSED;
            ST_TEARDOWN_WAIT: c = CODE_TEARDOWN_WAIT;
            ST_TEARDOWN_BOTH: c = CODE_TEARDOWN_BOTH;
            ST_TEARDOWN_LINGER: c = CODE_TEARDOWN_LINGER;
            ST_DATAGRAM_OPEN: c = CODE_DATAGRAM_OPEN;
            ST_RAW_IP_OPEN: c = CODE_RAW_IP_OPEN;
            ST_RAW_FRAME_OPEN: c = CODE_RAW_FRAME_OPEN;
            default: c = CODE_RELEASED;
        endcase
        return c;
    endfunction : code_of
    // command decode helper
    function automatic logic cmd_hit(sk_cmd_s c, logic [7:0] k);
        return c.valid && (c.code == k);
    endfunction : cmd_hit
    assign my_addr = STATE_CODE_BASE + 16'(SOCK_IDX) * SOCKET_STRIDE;
    assign is_tcp = !(state inside {ST_RELEASED, ST_DATAGRAM_OPEN,
        ST_RAW_IP_OPEN, ST_RAW_FRAME_OPEN});
    // tcp retry expiry only means something while a tcp socket is live
    assign expiry_hit = (pkt_evt.tcp_retry_expiry && is_tcp)
        || pkt_evt.resolution_expiry;
    assign abort = cmd_hit(socket_command, CMD_CLOSE) || expiry_hit;

    // next state; close and expiry take priority over everything
    always_comb begin
        next_state = state;
        next_session = session;
        if (abort) begin
            next_state = ST_RELEASED;
            next_session = 1'b0;
        end else begin
            unique case (state)
                ST_RELEASED: begin
                    if (cmd_hit(socket_command, CMD_OPEN)) begin
                        next_session = 1'b0;
                        if (socket_protocol_select == PROTO_TCP) begin
                            next_state = ST_TCP_INITIAL;
                        end else if (socket_protocol_select == PROTO_UDP) begin
                            next_state = ST_DATAGRAM_OPEN;
                        end else if (socket_protocol_select == PROTO_RAW_IP)
                        begin
                            next_state = ST_RAW_IP_OPEN;
                        end else if (SOCK_IDX == 0 &&
                            socket_protocol_select == PROTO_RAW_FRAME) begin
                            next_state = ST_RAW_FRAME_OPEN;
                        end else if (SOCK_IDX == 0 &&
                            socket_protocol_select == PROTO_SESSION) begin
                            next_session = 1'b1;
                        end
                    end else if (cmd_hit(socket_command, CMD_TEARDOWN)) begin
                        next_session = 1'b0;
                    end
                end
                ST_TCP_INITIAL: begin
                    if (cmd_hit(socket_command, CMD_LISTEN)) begin
                        next_state = ST_SERVER_WAITING;
                    end else if (cmd_hit(socket_command, CMD_CONNECT)) begin
                        next_state = ST_REQUEST_SENT;
                    end else if (cmd_hit(socket_command, CMD_TEARDOWN)) begin
                        next_state = ST_RELEASED;
                    end
                end
                ST_SERVER_WAITING: begin
                    if (cmd_hit(socket_command, CMD_TEARDOWN)) begin
                        next_state = ST_RELEASED;
                    end else if (pkt_evt.syn_rx) begin
                        next_state = ST_REQUEST_RECEIVED;
                    end
                end
                ST_REQUEST_SENT: begin
                    if (cmd_hit(socket_command, CMD_TEARDOWN)) begin
                        next_state = ST_RELEASED;
                    end else if (pkt_evt.synack_rx) begin
                        next_state = ST_CONNECTED;
                    end
                end
                ST_REQUEST_RECEIVED: begin
                    if (cmd_hit(socket_command, CMD_TEARDOWN)) begin
                        next_state = ST_RELEASED;
                    end else if (pkt_evt.synack_tx_ok) begin
                        next_state = ST_CONNECTED;
                    end
                end
                ST_CONNECTED: begin
                    if (cmd_hit(socket_command, CMD_TEARDOWN)) begin
                        next_state = ST_TEARDOWN_WAIT;
                    end else if (pkt_evt.fin_rx) begin
                        next_state = ST_HALF_CLOSED;
                    end
                end
                ST_HALF_CLOSED: begin
                    if (cmd_hit(socket_command, CMD_TEARDOWN)) begin
                        next_state = ST_TEARDOWN_BOTH;
                    end
                end
                ST_TEARDOWN_WAIT: begin
                    if (pkt_evt.fin_rx && pkt_evt.fin_ack_rx) begin
                        next_state = ST_TEARDOWN_LINGER;
                    end else if (pkt_evt.fin_rx) begin
                        next_state = ST_TEARDOWN_BOTH;
                    end
                end
                ST_TEARDOWN_BOTH: begin
                    if (pkt_evt.fin_ack_rx) begin
                        next_state = ST_TEARDOWN_LINGER;
                    end
                end
                ST_TEARDOWN_LINGER: begin
                    if (pkt_evt.teardown_done) begin
                        next_state = ST_RELEASED;
                    end
                end
                ST_DATAGRAM_OPEN, ST_RAW_IP_OPEN, ST_RAW_FRAME_OPEN: begin
                    if (cmd_hit(socket_command, CMD_TEARDOWN)) begin
                        next_state = ST_RELEASED;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= ST_RELEASED;
            session <= 1'b0;
        end else begin
            state <= next_state;
            session <= next_session;
        end
    end

    // status code held in a flop so reads never see decode glitches
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_code <= STATE_CODE_RESET;
        end else begin
            state_code <= code_of(next_state, next_session);
        end
    end

    // sticky timeout flag; a new expiry beats the host clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            timeout_flag <= 1'b0;
        end else if (expiry_hit) begin
            timeout_flag <= 1'b1;
        end else if (timeout_flag_ack) begin
            timeout_flag <= 1'b0;
        end
    end

    // register read; writes are decoded nowhere, so they do nothing
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == my_addr) begin
            reg_rdata <= state_code;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // requests to the packet engines, one cycle each
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            send_syn <= 1'b0;
            send_synack <= 1'b0;
            send_fin <= 1'b0;
        end else begin
            send_syn <= state != ST_REQUEST_SENT
                && next_state == ST_REQUEST_SENT;
            send_synack <= state != ST_REQUEST_RECEIVED
                && next_state == ST_REQUEST_RECEIVED;
            send_fin <= (state == ST_CONNECTED || state == ST_HALF_CLOSED)
                && next_state inside {ST_TEARDOWN_WAIT, ST_TEARDOWN_BOTH};
        end
    end

    // send and receive only where data may move
    assign data_enable = state inside {ST_CONNECTED, ST_HALF_CLOSED,
        ST_DATAGRAM_OPEN, ST_RAW_IP_OPEN, ST_RAW_FRAME_OPEN} || session;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            send_req <= 1'b0;
            recv_req <= 1'b0;
        end else begin
            send_req <= data_enable && !abort
                && cmd_hit(socket_command, CMD_SEND);
            recv_req <= data_enable && !abort
                && cmd_hit(socket_command, CMD_RECV);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_reset_released: assert property (
        @(posedge sys_clk) disable iff (1'b0)
        sys_rst |=> state_code == CODE_RELEASED)
        else $error("status not released after reset");
    a_close_releases: assert property (
        cmd_hit(socket_command, CMD_CLOSE) |=> state_code == CODE_RELEASED)
        else $error("close did not release socket");
    a_open_tcp: assert property (
        state == ST_RELEASED && !session && !expiry_hit
        && cmd_hit(socket_command, CMD_OPEN)
        && socket_protocol_select == PROTO_TCP
        |=> state_code == CODE_TCP_INITIAL)
        else $error("tcp open did not reach initial");
    a_listen_wait: assert property (
        state == ST_TCP_INITIAL && !abort
        && cmd_hit(socket_command, CMD_LISTEN)
        |=> state_code == CODE_SERVER_WAITING ##0 !send_syn)
        else $error("listen did not reach server waiting");
    a_connect_syn: assert property (
        state == ST_TCP_INITIAL && !abort
        && cmd_hit(socket_command, CMD_CONNECT)
        |=> state_code == CODE_REQUEST_SENT && send_syn)
        else $error("connect did not send request");
    a_expiry_flag: assert property (
        expiry_hit |=> timeout_flag && state_code == CODE_RELEASED)
        else $error("expiry did not flag and release");
    a_flag_sticky: assert property (
        timeout_flag && !timeout_flag_ack |=> timeout_flag)
        else $error("timeout flag lost without ack");
    a_fin_half: assert property (
        state == ST_CONNECTED && pkt_evt.fin_rx && !abort
        && !socket_command.valid
        |=> state_code == CODE_HALF_CLOSED)
        else $error("peer fin did not half close");
    a_udp_open: assert property (
        state == ST_RELEASED && !session && !expiry_hit
        && cmd_hit(socket_command, CMD_OPEN)
        && socket_protocol_select == PROTO_UDP
        |=> state_code == CODE_DATAGRAM_OPEN)
        else $error("udp open failed");
    a_raw_only_zero: assert property (
        state_code == CODE_RAW_FRAME_OPEN
        || state_code == CODE_SESSION_SETUP |-> SOCK_IDX == 0)
        else $error("raw frame on nonzero socket");
    a_reg_read: assert property (
        reg_rd && reg_addr == my_addr |=> reg_rdata == $past(state_code))
        else $error("status read wrong value");
    a_linger_done: assert property (
        state == ST_TEARDOWN_LINGER && pkt_evt.teardown_done
        |=> state_code == CODE_RELEASED && !data_enable)
        else $error("linger did not release");

    c_client_connect: cover property (
        state == ST_REQUEST_SENT ##1 state == ST_CONNECTED);
    c_server_connect: cover property (
        state == ST_REQUEST_RECEIVED ##1 state == ST_CONNECTED);
    c_active_close: cover property (
        state == ST_TEARDOWN_LINGER ##1 state == ST_RELEASED);
    c_flag_race: cover property (expiry_hit && timeout_flag_ack);
endmodule : sk_socket_status

/* File: hdl/sk_pkg.sv */
package sk_pkg;
    // status codes reported through socket_state_code
    localparam logic [7:0] CODE_RELEASED = 8'h00;
    localparam logic [7:0] CODE_TCP_INITIAL = 8'h13;
    localparam logic [7:0] CODE_SERVER_WAITING = 8'h14;
    localparam logic [7:0] CODE_REQUEST_SENT = 8'h15;
    localparam logic [7:0] CODE_REQUEST_RECEIVED = 8'h16;
    localparam logic [7:0] CODE_CONNECTED = 8'h17;
    localparam logic [7:0] CODE_TEARDOWN_WAIT = 8'h18;
    localparam logic [7:0] CODE_TEARDOWN_BOTH = 8'h1A;
    localparam logic [7:0] CODE_TEARDOWN_LINGER = 8'h1B;
    localparam logic [7:0] CODE_HALF_CLOSED = 8'h1C;
    localparam logic [7:0] CODE_DATAGRAM_OPEN = 8'h22;
    localparam logic [7:0] CODE_RAW_IP_OPEN = 8'h32;
    localparam logic [7:0] CODE_RAW_FRAME_OPEN = 8'h42;
    localparam logic [7:0] CODE_SESSION_SETUP = 8'h5F;
    localparam logic [7:0] STATE_CODE_RESET = 8'h00;
    // register placement: base plus socket index times stride
    localparam logic [15:0] STATE_CODE_BASE = 16'h4003;
    localparam logic [15:0] SOCKET_STRIDE = 16'h0100;
    // socket_command codes
    localparam logic [7:0] CMD_OPEN = 8'h01;
    localparam logic [7:0] CMD_LISTEN = 8'h02;
    localparam logic [7:0] CMD_CONNECT = 8'h04;
    localparam logic [7:0] CMD_TEARDOWN = 8'h08;
    localparam logic [7:0] CMD_CLOSE = 8'h10;
    localparam logic [7:0] CMD_SEND = 8'h20;
    localparam logic [7:0] CMD_RECV = 8'h40;
    // socket_protocol_select low nibble
    localparam logic [3:0] PROTO_TCP = 4'h1;
    localparam logic [3:0] PROTO_UDP = 4'h2;
    localparam logic [3:0] PROTO_RAW_IP = 4'h3;
    localparam logic [3:0] PROTO_RAW_FRAME = 4'h4;
    localparam logic [3:0] PROTO_SESSION = 4'h5;

    // events from the packet engines, one-cycle pulses
    typedef struct packed {
        logic syn_rx;
        logic synack_rx;
        logic synack_tx_ok;
        logic fin_rx;
        logic fin_ack_rx;
        logic teardown_done;
        logic tcp_retry_expiry;
        logic resolution_expiry;
    } sk_evt_s;

    // command strobe with its code
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } sk_cmd_s;
endpackage : sk_pkg

/* File: bench/sk_peer_model.sv */
`timescale 1ns/1ps
// far side stand-in: answers the packet engine requests after a lag
module sk_peer_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // requests from the socket
    input wire logic send_syn,
    input wire logic send_synack,
    input wire logic send_fin,
    // behaviour control from the bench
    input wire logic silent,
    input wire logic [31:0] lag,
    input wire sk_pkg::sk_evt_s inj,
    // events back to the socket
    output sk_pkg::sk_evt_s pkt_evt
);
    import sk_pkg::*;
    sk_evt_s gen;
    logic [2:0] kind;
    int unsigned cnt;

    // bench injections ride on top of generated answers
    assign pkt_evt = gen | inj;

    // one outstanding answer at a time; a silent peer lets the retry expire
    always @(posedge sys_clk) begin
        gen <= '0;
        if (sys_rst) begin
            kind <= 3'd0;
        end else if (send_syn) begin
            kind <= 3'd1;
            cnt <= lag;
        end else if (send_synack) begin
            kind <= 3'd2;
            cnt <= lag;
        end else if (send_fin) begin
            kind <= 3'd3;
            cnt <= lag;
        end else if (kind != 3'd0 && cnt != 0) begin
            cnt <= cnt - 1;
        end else if (kind != 3'd0) begin
            kind <= 3'd0;
            case (kind)
                3'd1: begin
                    gen.synack_rx <= !silent;
                    gen.tcp_retry_expiry <= silent;
                end
                3'd2: begin
                    gen.synack_tx_ok <= !silent;
                    gen.tcp_retry_expiry <= silent;
                end
                3'd3: begin
                    gen.fin_ack_rx <= 1'b1;
                    kind <= 3'd4;
                end
                default: gen.teardown_done <= 1'b1;
            endcase
        end
    end
endmodule : sk_peer_model

/* File: bench/sk_socket_status_tb_top.sv */
`timescale 1ns/1ps
module sk_socket_status_tb_top;
    import sk_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, rdata_b, state_code, code_b;
    sk_cmd_s socket_command = '0;
    logic [3:0] socket_protocol_select = 4'h0;
    logic timeout_flag_ack = 1'b0;
    sk_evt_s pkt_evt;
    sk_evt_s inj = '0;
    logic send_syn, send_synack, send_fin, send_req, recv_req;
    logic timeout_flag, data_enable;
    logic silent = 1'b0;
    int unsigned lag = 2;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;

    // socket zero is the main device; socket one shares all inputs
    sk_socket_status #(.SOCK_IDX(0)) i_sk_socket_status (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .socket_command(socket_command),
        .socket_protocol_select(socket_protocol_select),
        .timeout_flag_ack(timeout_flag_ack), .pkt_evt(pkt_evt),
        .send_syn(send_syn), .send_synack(send_synack),
        .send_fin(send_fin), .send_req(send_req), .recv_req(recv_req),
        .state_code(state_code), .timeout_flag(timeout_flag),
        .data_enable(data_enable));
    sk_socket_status #(.SOCK_IDX(1)) i_sk_socket_status_1 (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(rdata_b), .socket_command(socket_command),
        .socket_protocol_select(socket_protocol_select),
        .timeout_flag_ack(timeout_flag_ack), .pkt_evt(pkt_evt),
        .send_syn(), .send_synack(), .send_fin(), .send_req(),
        .recv_req(), .state_code(code_b), .timeout_flag(),
        .data_enable());
    sk_peer_model i_sk_peer_model (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .send_syn(send_syn),
        .send_synack(send_synack), .send_fin(send_fin), .silent(silent),
        .lag(lag), .inj(inj), .pkt_evt(pkt_evt));

    // clock and hang guard
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // every task starts and ends just after a rising edge
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic command(input logic [7:0] code);
        socket_command = '{valid: 1'b1, code: code};
        tick();
        socket_command = '0;
    endtask : command

    task automatic open_as(input logic [3:0] proto);
        socket_protocol_select = proto;
        command(CMD_OPEN);
    endtask : open_as

    task automatic inject(input sk_evt_s e);
        inj = e;
        tick();
        inj = '0;
    endtask : inject

    task automatic read_reg(input logic [15:0] a, input logic [7:0] ea,
                            input logic [7:0] eb);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        check(reg_rdata, ea);
        check(rdata_b, eb);
    endtask : read_reg

    // bounded wait for a status code, then judge it
    task automatic wait_code(input logic [7:0] exp);
        for (int n = 0; n < 20 && state_code !== exp; n++) tick();
        check(state_code, exp);
    endtask : wait_code

    task automatic ack_flag();
        check(8'(timeout_flag), 8'h01);
        timeout_flag_ack = 1'b1;
        tick();
        timeout_flag_ack = 1'b0;
        check(8'(timeout_flag), 8'h00);
    endtask : ack_flag

    task automatic test_reset_regs();
        check(state_code, CODE_RELEASED);
        reg_addr = STATE_CODE_BASE;
        reg_wdata = 8'hFF;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        check(state_code, CODE_RELEASED);
        read_reg(STATE_CODE_BASE, 8'h00, 8'h00);
        read_reg(16'h4002, 8'h00, 8'h00);
        $display("test reset_regs done");
    endtask : test_reset_regs

    task automatic test_open_modes();
        logic [3:0] pr [5];
        logic [7:0] cd [5];
        logic [7:0] eb;
        pr = '{PROTO_TCP, PROTO_UDP, PROTO_RAW_IP, PROTO_RAW_FRAME,
               PROTO_SESSION};
        cd = '{CODE_TCP_INITIAL, CODE_DATAGRAM_OPEN, CODE_RAW_IP_OPEN,
               CODE_RAW_FRAME_OPEN, CODE_SESSION_SETUP};
        for (int i = 0; i < 5; i++) begin
            open_as(pr[i]);
            eb = (i < 3) ? cd[i] : CODE_RELEASED;
            check(state_code, cd[i]);
            check(code_b, eb);
            read_reg(STATE_CODE_BASE, cd[i], 8'h00);
            read_reg(STATE_CODE_BASE + SOCKET_STRIDE, 8'h00, eb);
            command(CMD_CLOSE);
            check(state_code, CODE_RELEASED);
        end
        $display("test open_modes done");
    endtask : test_open_modes

    task automatic test_client();
        open_as(PROTO_TCP);
        command(CMD_CONNECT);
        check(state_code, CODE_REQUEST_SENT);
        check(8'(send_syn), 8'h01);
        wait_code(CODE_CONNECTED);
        check(8'(data_enable), 8'h01);
        command(CMD_SEND);
        check(8'(send_req), 8'h01);
        command(CMD_RECV);
        check(8'(recv_req), 8'h01);
        inject('{fin_rx: 1'b1, default: 1'b0});
        check(state_code, CODE_HALF_CLOSED);
        command(CMD_SEND);
        check(8'(send_req), 8'h01);
        command(CMD_TEARDOWN);
        check(state_code, CODE_TEARDOWN_BOTH);
        check(8'(send_fin), 8'h01);
        wait_code(CODE_TEARDOWN_LINGER);
        wait_code(CODE_RELEASED);
        check(8'(data_enable), 8'h00);
        $display("test client done");
    endtask : test_client

    task automatic test_server();
        open_as(PROTO_TCP);
        command(CMD_LISTEN);
        check(state_code, CODE_SERVER_WAITING);
        inject('{syn_rx: 1'b1, default: 1'b0});
        check(state_code, CODE_REQUEST_RECEIVED);
        check(8'(send_synack), 8'h01);
        wait_code(CODE_CONNECTED);
        command(CMD_TEARDOWN);
        check(state_code, CODE_TEARDOWN_WAIT);
        check(8'(send_fin), 8'h01);
        inject('{fin_rx: 1'b1, default: 1'b0});
        check(state_code, CODE_TEARDOWN_BOTH);
        wait_code(CODE_TEARDOWN_LINGER);
        wait_code(CODE_RELEASED);
        $display("test server done");
    endtask : test_server

    task automatic test_timeouts();
        silent = 1'b1;
        open_as(PROTO_TCP);
        command(CMD_CONNECT);
        wait_code(CODE_RELEASED);
        ack_flag();
        open_as(PROTO_TCP);
        command(CMD_LISTEN);
        inject('{syn_rx: 1'b1, default: 1'b0});
        wait_code(CODE_RELEASED);
        ack_flag();
        silent = 1'b0;
        open_as(PROTO_UDP);
        inject('{resolution_expiry: 1'b1, default: 1'b0});
        check(state_code, CODE_RELEASED);
        ack_flag();
        command(CMD_LISTEN);
        check(state_code, CODE_RELEASED);
        open_as(PROTO_TCP);
        command(CMD_TEARDOWN);
        check(state_code, CODE_RELEASED);
        $display("test timeouts done");
    endtask : test_timeouts

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // reset for four cycles, then run every scenario in turn
    initial begin
        repeat (4) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        test_reset_regs();
        test_open_modes();
        test_client();
        test_server();
        test_timeouts();
        complete_run();
    end
endmodule : sk_socket_status_tb_top
